// *** include/hppc_pkg.sv ***
// Shared constants and types for the haptic playback power controller.
// Assumes a 50 MHz core clock and a classic Wishbone register port.
package hppc_pkg;

   // Core clock and documented times, each in its own unit
   localparam int CLK_HZ = 50_000_000;
   localparam int STARTUP_US = 2000;
   localparam int SAMPLE_HZ = 8000;
   localparam int TIMEOUT_STEP_MS = 5;

   // Cycle counts derived from the times
   localparam int STARTUP_CYC = CLK_HZ / 1_000_000 * STARTUP_US;
   localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
   localparam int TIMEOUT_STEP_CYC = CLK_HZ / 1000 * TIMEOUT_STEP_MS;

   localparam int QUEUE_DEPTH = 100;
   localparam int SAMPLE_W = 8;
   localparam int TMR_W = 21;
   localparam int ADR_W = 8;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_STATUS = 6'h00;
   localparam logic [5:0] IDX_CTRL = 6'h01;
   localparam logic [5:0] IDX_INT_STAT = 6'h03;
   localparam logic [5:0] IDX_INT_CLR = 6'h04;
   localparam logic [5:0] IDX_INT_EN = 6'h05;
   localparam logic [5:0] IDX_QUEUE = 6'h0b;

   // Control register layout
   localparam int CTRL_W = 10;
   localparam int CTRL_STANDBY = 0;
   localparam int CTRL_FORCE = 1;
   localparam int CTRL_SRST = 2;
   localparam int CTRL_GAIN = 3;
   localparam int CTRL_TMO = 5;
   localparam int CTRL_MODE = 7;
   localparam int CTRL_PLAY = 9;
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h001;

   // Status register layout
   localparam int STAT_STATE = 0;
   localparam int STAT_EMPTY = 3;
   localparam int STAT_FULL = 4;
   localparam int STAT_STAGES = 5;
   localparam int STAT_CODE = 8;
   localparam int STAT_COUNT = 16;

   // Interrupt bit layout
   localparam int IRQ_W = 5;
   localparam int IRQ_WAKE = 0;
   localparam int IRQ_IDLE = 1;
   localparam int IRQ_RAMP = 2;
   localparam int IRQ_FULL = 3;
   localparam int IRQ_DROP = 4;

   localparam logic [SAMPLE_W-1:0] MID_CODE = 8'h00;
   localparam logic [3:0] FRAME_LAST = 4'h7;

   typedef enum logic [1:0] {
      MODE_QUEUE = 2'h0,
      MODE_RAM = 2'h1,
      MODE_SYNTH = 2'h2,
      MODE_ANALOG = 2'h3
   } hppc_mode_e;

   // Full-scale peak volts and analog gain (tenths of dB) per gain code
   typedef enum logic [1:0] {
      GAIN_25V = 2'h0,
      GAIN_50V = 2'h1,
      GAIN_75V = 2'h2,
      GAIN_100V = 2'h3
   } hppc_gain_e;
   localparam int GAIN_PEAK_V [4] = '{25, 50, 75, 100};
   localparam int GAIN_ANALOG_DB10 [4] = '{288, 348, 384, 407};

   // Gray coded along standby, idle, wake, play, timeout, ramp
   typedef enum logic [2:0] {
      ST_STANDBY = 3'h0,
      ST_IDLE = 3'h1,
      ST_WAKE = 3'h3,
      ST_PLAY = 3'h2,
      ST_TIMEOUT = 3'h6,
      ST_RAMP = 3'h7
   } hppc_state_e;

   // Serial converter link outputs
   typedef struct packed {
      logic sync_n;
      logic sdo;
   } hppc_dac_s;

endpackage

// *** rtl/hppc_queue.sv ***
// Sample queue for the playback controller, first in first out.
// Assumes same-clock push and pop; clr empties it at once.
module hppc_queue #(
   parameter int W = 8,
   parameter int D = 100
) (
   input wire logic clk, // Core clock
   input wire logic rst, // Async reset, high
   input wire logic ce, // Clock enable
   input wire logic clr, // Flush all entries
   input wire logic push_valid, // Write request
   output logic push_ready, // Room for a write
   input wire logic [W-1:0] push_data, // Write data
   output logic pop_valid, // Entry available
   input wire logic pop_ready, // Take head entry
   output logic [W-1:0] pop_data, // Head entry
   output logic [$clog2(D+1)-1:0] count // Entries held
);
   localparam int PW = $clog2(D);
   localparam int CW = $clog2(D+1);
   localparam logic [PW-1:0] LAST = PW'(D - 1);
   localparam logic [CW-1:0] FULLC = CW'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } hppc_q_s;

   hppc_q_s s;
   hppc_q_s next_s;
   logic do_push;
   logic do_pop;

   always_comb begin
      next_s = s;
      push_ready = s.cnt != FULLC;
      pop_valid = s.cnt != '0;
      pop_data = s.mem[s.rp];
      count = s.cnt;
      do_push = push_valid && push_ready;
      do_pop = pop_ready && pop_valid;
      if (do_push) begin
         next_s.mem[s.wp] = push_data;
         next_s.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
      end
      if (do_pop) begin
         next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
      end
      if (do_push && !do_pop) begin
         next_s.cnt = s.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
         next_s.cnt = s.cnt - 1'b1;
      end
      if (clr) begin
         next_s.wp = '0;
         next_s.rp = '0;
         next_s.cnt = '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end
endmodule

// *** rtl/hppc_top.sv ***
// Power sequencing and playback control of a piezo haptic driver.
// Assumes a Wishbone classic master on core_clk and an external serial
// converter whose clock dac_sclk is asynchronous to core_clk.
//
// Summary of operation
// - Queue write wakes stages, plays after 2 ms
// - Queue empty starts shutdown without host command
// - Nonzero converter ramps to mid-scale after timeout
// - Queue writes during ramp-down are dropped
// - Standby bit falling makes device ready
// - Logic drives boost and amplifier enables itself
// - Data or play bit wakes; output after wake
// - Force-on starts wake, holds stages enabled
// - Standby bit rising enters lowest-power standby
// - Standby high ignores all playback requests
// - Soft reset aborts, restores defaults, enters standby
// - Two-bit gain selects 25 to 100 V
// - Queue write not acknowledged while queue full
// - Selectable 5 to 20 ms timeout, then idle
// - Signed samples played at 8 kHz
module hppc_top #(
   parameter int STARTUP_CYC = hppc_pkg::STARTUP_CYC,
   parameter int SAMPLE_CYC = hppc_pkg::SAMPLE_CYC,
   parameter int TIMEOUT_STEP_CYC = hppc_pkg::TIMEOUT_STEP_CYC,
   parameter int QUEUE_DEPTH = hppc_pkg::QUEUE_DEPTH
) (
   input wire logic core_clk, // Core clock
   input wire logic rst, // Async reset, high
   input wire logic ce, // Clock enable
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_we_i, // Write
   input wire logic [hppc_pkg::ADR_W-1:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte lanes
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Acknowledge
   input wire logic dac_sclk, // Converter link clock
   output hppc_pkg::hppc_dac_s dac, // Converter link frame and data
   output logic [hppc_pkg::SAMPLE_W-1:0] conv_code, // Converter code
   output logic boost_en, // Boost converter enable
   output logic amp_en, // Amplifier enable
   output logic [1:0] gain_sel, // Gain code
   output logic irq // Interrupt, level
);
   localparam int SW = hppc_pkg::SAMPLE_W;
   localparam int TW = hppc_pkg::TMR_W;
   localparam int CW = $clog2(QUEUE_DEPTH+1);
   localparam logic [TW-1:0] STARTUP_LAST = TW'(STARTUP_CYC - 1);
   localparam logic [TW-1:0] SAMPLE_LAST = TW'(SAMPLE_CYC - 1);

   typedef struct packed {
      hppc_pkg::hppc_state_e st;
      logic [hppc_pkg::CTRL_W-1:0] ctrl;
      logic [TW-1:0] tmr;
      logic [TW-1:0] tick;
      logic [SW-1:0] code;
      logic en;
      logic [hppc_pkg::IRQ_W-1:0] ists;
      logic [hppc_pkg::IRQ_W-1:0] ien;
      logic ack;
      logic [31:0] rdat;
      logic irq;
      logic [2:0] sclk_s;
      logic [SW-1:0] sh;
      logic [3:0] nbit;
      logic pend;
      logic sync_n;
      logic sdo;
   } hppc_top_s;

   localparam hppc_top_s RST_S = '{
      st: hppc_pkg::ST_STANDBY,
      ctrl: hppc_pkg::CTRL_RST,
      sync_n: 1'b1,
      default: '0
   };

   hppc_top_s s;
   hppc_top_s next_s;

   logic q_clr;
   logic q_push;
   logic q_ready;
   logic q_valid;
   logic q_pop;
   logic [SW-1:0] q_data;
   logic [CW-1:0] q_count;

   logic req;
   logic wr;
   logic [5:0] idx;
   logic [31:0] mask;
   logic [31:0] wdat;
   logic qwr;
   logic drop;
   logic srst;
   logic standby;
   logic force_on;
   logic play_req;
   logic tick_hit;
   logic sclk_fall;
   logic [TW-1:0] tmo_last;
   logic [hppc_pkg::IRQ_W-1:0] evt;
   logic [hppc_pkg::IRQ_W-1:0] clr;

   hppc_queue #(
      .W(SW),
      .D(QUEUE_DEPTH)
   ) u_queue (
      .clk(core_clk),
      .rst(rst),
      .ce(ce),
      .clr(q_clr),
      .push_valid(q_push),
      .push_ready(q_ready),
      .push_data(wb_dat_i[SW-1:0]),
      .pop_valid(q_valid),
      .pop_ready(q_pop),
      .pop_data(q_data),
      .count(q_count)
   );

   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      evt = '0;
      clr = '0;
      q_pop = 1'b0;
      next_s.sclk_s = {s.sclk_s[1:0], dac_sclk};
      sclk_fall = s.sclk_s[2] && !s.sclk_s[1];

      // Bus decode
      req = wb_cyc_i && wb_stb_i && !s.ack;
      wr = req && wb_we_i;
      idx = wb_adr_i[hppc_pkg::ADR_W-1:2];
      mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
              {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wdat = wb_dat_i & mask;
      standby = s.ctrl[hppc_pkg::CTRL_STANDBY];
      force_on = s.ctrl[hppc_pkg::CTRL_FORCE] && !standby;
      play_req = s.ctrl[hppc_pkg::CTRL_PLAY] && !standby;
      qwr = wr && idx == hppc_pkg::IDX_QUEUE && wb_sel_i[0];
      drop = qwr && (s.st == hppc_pkg::ST_RAMP
         || s.st == hppc_pkg::ST_STANDBY || standby);
      srst = wr && idx == hppc_pkg::IDX_CTRL && wb_sel_i[0]
         && wb_dat_i[hppc_pkg::CTRL_SRST];
      q_push = qwr && !drop;
      q_clr = standby || srst;
      evt[hppc_pkg::IRQ_DROP] = drop;
      evt[hppc_pkg::IRQ_FULL] = qwr && !drop && !q_ready;
      // Holding ack off is the refusal; the master retries the same byte
      if (req && !(qwr && !drop && !q_ready)) begin
         next_s.ack = 1'b1;
      end

      // Register reads; unmapped addresses read zero and still ack
      next_s.rdat = '0;
      if (req && !wb_we_i) begin
         unique case (idx)
            hppc_pkg::IDX_STATUS: begin
               next_s.rdat[hppc_pkg::STAT_STATE +: 3] = s.st;
               next_s.rdat[hppc_pkg::STAT_EMPTY] = !q_valid;
               next_s.rdat[hppc_pkg::STAT_FULL] = !q_ready;
               next_s.rdat[hppc_pkg::STAT_STAGES] = s.en;
               next_s.rdat[hppc_pkg::STAT_CODE +: SW] = s.code;
               next_s.rdat[hppc_pkg::STAT_COUNT +: CW] = q_count;
            end
            hppc_pkg::IDX_CTRL: begin
               next_s.rdat[hppc_pkg::CTRL_W-1:0] = s.ctrl;
            end
            hppc_pkg::IDX_INT_STAT: begin
               next_s.rdat[hppc_pkg::IRQ_W-1:0] = s.ists;
            end
            hppc_pkg::IDX_INT_EN: begin
               next_s.rdat[hppc_pkg::IRQ_W-1:0] = s.ien;
            end
            default: begin
               next_s.rdat = '0;
            end
         endcase
      end

      // Register writes
      if (wr && idx == hppc_pkg::IDX_CTRL) begin
         next_s.ctrl = (s.ctrl & ~mask[hppc_pkg::CTRL_W-1:0])
            | wdat[hppc_pkg::CTRL_W-1:0];
         next_s.ctrl[hppc_pkg::CTRL_SRST] = 1'b0;
      end
      if (wr && idx == hppc_pkg::IDX_INT_EN) begin
         next_s.ien = (s.ien & ~mask[hppc_pkg::IRQ_W-1:0])
            | wdat[hppc_pkg::IRQ_W-1:0];
      end
      if (wr && idx == hppc_pkg::IDX_INT_CLR) begin
         clr = wdat[hppc_pkg::IRQ_W-1:0];
      end

      // Sample clock runs free so the 8 kHz grid never drifts
      tick_hit = s.tick == SAMPLE_LAST;
      next_s.tick = tick_hit ? '0 : s.tick + 1'b1;
      tmo_last = TW'((int'(s.ctrl[hppc_pkg::CTRL_TMO +: 2]) + 1)
         * TIMEOUT_STEP_CYC - 1);

      unique case (s.st)
         hppc_pkg::ST_STANDBY: begin
            next_s.code = hppc_pkg::MID_CODE;
            if (!standby) begin
               next_s.st = hppc_pkg::ST_IDLE;
            end
         end
         hppc_pkg::ST_IDLE: begin
            if (force_on || q_valid || play_req) begin
               next_s.st = hppc_pkg::ST_WAKE;
               next_s.tmr = '0;
               next_s.ctrl[hppc_pkg::CTRL_PLAY] = 1'b0;
            end
         end
         hppc_pkg::ST_WAKE: begin
            // Converter held at mid-scale, queue keeps filling
            next_s.code = hppc_pkg::MID_CODE;
            next_s.tmr = s.tmr + 1'b1;
            if (s.tmr == STARTUP_LAST) begin
               next_s.st = hppc_pkg::ST_PLAY;
               evt[hppc_pkg::IRQ_WAKE] = 1'b1;
            end
         end
         hppc_pkg::ST_PLAY: begin
            next_s.ctrl[hppc_pkg::CTRL_PLAY] = 1'b0;
            if (tick_hit) begin
               if (q_valid) begin
                  q_pop = 1'b1;
                  next_s.code = q_data;
               end else begin
                  next_s.st = hppc_pkg::ST_TIMEOUT;
                  next_s.tmr = '0;
               end
            end
         end
         hppc_pkg::ST_TIMEOUT: begin
            next_s.tmr = s.tmr + 1'b1;
            if (q_valid || play_req) begin
               next_s.st = hppc_pkg::ST_PLAY;
               next_s.ctrl[hppc_pkg::CTRL_PLAY] = 1'b0;
            end else if (force_on) begin
               // Stages stay up under force-on, so no timeout runs
               next_s.tmr = '0;
            end else if (s.tmr == tmo_last) begin
               if (s.code != hppc_pkg::MID_CODE) begin
                  next_s.st = hppc_pkg::ST_RAMP;
                  evt[hppc_pkg::IRQ_RAMP] = 1'b1;
               end else begin
                  next_s.st = hppc_pkg::ST_IDLE;
                  evt[hppc_pkg::IRQ_IDLE] = 1'b1;
               end
            end
         end
         hppc_pkg::ST_RAMP: begin
            // One code step per sample keeps the slew gentle
            if (s.code == hppc_pkg::MID_CODE) begin
               next_s.st = hppc_pkg::ST_IDLE;
               evt[hppc_pkg::IRQ_IDLE] = 1'b1;
            end else if (tick_hit) begin
               next_s.code = s.code[SW-1] ? s.code + 1'b1
                  : s.code - 1'b1;
            end
         end
         default: begin
            next_s.st = hppc_pkg::ST_STANDBY;
         end
      endcase

      if (standby) begin
         next_s.st = hppc_pkg::ST_STANDBY;
         next_s.ctrl[hppc_pkg::CTRL_PLAY] = 1'b0;
      end

      // Stage enables follow the state, or force-on outside standby
      next_s.en = (next_s.st != hppc_pkg::ST_STANDBY
         && next_s.st != hppc_pkg::ST_IDLE)
         || (force_on && !next_s.ctrl[hppc_pkg::CTRL_STANDBY]);

      // Converter link: data changes on the falling edge of dac_sclk
      if (sclk_fall) begin
         if (s.nbit != '0) begin
            next_s.sdo = s.sh[SW-1];
            next_s.sh = {s.sh[SW-2:0], 1'b0};
            next_s.nbit = s.nbit - 1'b1;
         end else if (!s.sync_n) begin
            next_s.sync_n = 1'b1;
         end else if (s.pend) begin
            next_s.sync_n = 1'b0;
            next_s.sdo = s.code[SW-1];
            next_s.sh = {s.code[SW-2:0], 1'b0};
            next_s.nbit = hppc_pkg::FRAME_LAST;
            next_s.pend = 1'b0;
         end
      end
      if (next_s.code != s.code) begin
         next_s.pend = 1'b1;
      end

      // Set wins over a clear in the same cycle
      next_s.ists = (s.ists & ~clr) | evt;

      if (srst) begin
         next_s = RST_S;
         next_s.sclk_s = {s.sclk_s[1:0], dac_sclk};
         next_s.ack = 1'b1;
      end
      next_s.irq = |(next_s.ists & next_s.ien);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= RST_S;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign wb_dat_o = s.rdat;
   assign wb_ack_o = s.ack;
   assign dac.sync_n = s.sync_n;
   assign dac.sdo = s.sdo;
   assign conv_code = s.code;
   assign boost_en = s.en;
   assign amp_en = s.en;
   assign gain_sel = s.ctrl[hppc_pkg::CTRL_GAIN +: 2];
   assign irq = s.irq;
endmodule

// *** verif/hppc_dac_rx.sv ***
// Serial converter model: makes the link clock, takes 8 bits per frame.
// Assumes bits are taken on the rising link clock while sync_n is low.
module hppc_dac_rx (
   output logic dac_sclk, // Link clock, free running
   input wire hppc_pkg::hppc_dac_s dac, // Frame and data
   output logic [7:0] rx_code, // Last complete code
   output int rx_count // Complete frames
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh;
   int nb;
   initial begin
      dac_sclk = 1'b0;
      rx_code = 8'h00;
      rx_count = 0;
      sh = 8'h00;
      nb = 0;
   end
   // Runs free: the controller can only open a frame on a falling edge
   always #80 dac_sclk = ~dac_sclk;
   always @(posedge dac_sclk) begin
      if (!dac.sync_n) begin
         sh = {sh[6:0], dac.sdo};
         nb++;
      end
   end
   // A short frame is discarded, as a real converter would
   always @(posedge dac.sync_n) begin
      if (nb == 8) begin
         rx_code = sh;
         rx_count++;
      end
      nb = 0;
   end
endmodule

// *** verif/hppc_monitor.sv ***
// Concurrent checks on the ports of the playback power controller.
// Assumes one core clock domain and the async high reset rst.
module hppc_monitor (
   input wire logic core_clk, // Core clock
   input wire logic rst, // Async reset, high
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_we_i, // Write
   input wire logic [7:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte lanes
   input wire logic [31:0] wb_dat_i, // Write data
   input wire logic [31:0] wb_dat_o, // Read data
   input wire logic wb_ack_o, // Acknowledge
   input wire hppc_pkg::hppc_dac_s dac, // Converter link
   input wire logic [7:0] conv_code, // Converter code
   input wire logic boost_en, // Boost enable
   input wire logic amp_en, // Amplifier enable
   input wire logic [1:0] gain_sel, // Gain code
   input wire logic irq // Interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic ctrl_wr;
   assign ctrl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] &&
      wb_adr_i[7:2] == hppc_pkg::IDX_CTRL;
   sequence s_frame_open;
      $fell(dac.sync_n);
   endsequence
   sequence s_frame_hold;
      (!dac.sync_n)[*8];
   endsequence
   a_frame_bits: assert property (s_frame_open |-> s_frame_hold)
      else $error("converter frame closed too early");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
      else $error("ack without a request");
   a_rdat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_stage_pair: assert property (boost_en == amp_en)
      else $error("stage enables differ");
   a_wake_quiet: assert property ($rose(boost_en) |->
      (conv_code == 8'h00)[*8])
      else $error("converter moved during wake");
   a_gain_track: assert property (ctrl_wr && !wb_dat_i[2] |->
      ##2 gain_sel == $past(wb_dat_i[4:3], 2))
      else $error("gain output does not follow control");
   a_standby_enter: assert property (ctrl_wr && wb_dat_i[0] |->
      ##3 (!boost_en)[*2])
      else $error("stages on after standby");
   a_force_wake: assert property (ctrl_wr && wb_dat_i[2:0] == 3'h2 |->
      ##[1:4] boost_en)
      else $error("force-on did not wake stages");
   a_soft_reset: assert property (ctrl_wr && wb_dat_i[2] |=>
      gain_sel == 2'h0 && !boost_en && !irq)
      else $error("soft reset left state behind");
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the playback power controller.
// Assumes shortened counts and a model of the serial converter.
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin \
   miscompares++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); \
   end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SU = 50;
   localparam int SC = 20;
   localparam int TS = 100;
   localparam logic [7:0] A_STAT = {hppc_pkg::IDX_STATUS, 2'b00};
   localparam logic [7:0] A_CTRL = {hppc_pkg::IDX_CTRL, 2'b00};
   localparam logic [7:0] A_IST = {hppc_pkg::IDX_INT_STAT, 2'b00};
   localparam logic [7:0] A_ICLR = {hppc_pkg::IDX_INT_CLR, 2'b00};
   localparam logic [7:0] A_IEN = {hppc_pkg::IDX_INT_EN, 2'b00};
   localparam logic [7:0] A_Q = {hppc_pkg::IDX_QUEUE, 2'b00};
   logic core_clk, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic dac_sclk, boost_en, amp_en, irq;
   logic [7:0] wb_adr_i, conv_code, rx_code, last_code;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [1:0] gain_sel;
   hppc_pkg::hppc_dac_s dac;
   int rx_count, miscompares, checked, n;
   logic [7:0] seen[$];
   hppc_top #(.STARTUP_CYC(SU), .SAMPLE_CYC(SC), .TIMEOUT_STEP_CYC(TS),
      .QUEUE_DEPTH(4)) dut (.core_clk(core_clk), .rst(rst), .ce(ce),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dac_sclk(dac_sclk),
      .dac(dac), .conv_code(conv_code), .boost_en(boost_en),
      .amp_en(amp_en), .gain_sel(gain_sel), .irq(irq));
   hppc_dac_rx u_rx (.dac_sclk(dac_sclk), .dac(dac), .rx_code(rx_code),
      .rx_count(rx_count));
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (!rst && conv_code !== last_code) seen.push_back(conv_code);
      last_code <= conv_code;
   end
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output int k);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      k = 0;
      // No local limit: only the watchdog may end a wait for ack
      do begin @(posedge core_clk); k++; end
      while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      int k;
      wb(1'b1, a, d, r, k);
   endtask
   task automatic wait_boost(input logic v);
      n = 0;
      while (boost_en !== v && n < 5000) begin @(posedge core_clk); n++; end
   endtask
   task automatic chk_seen(input logic [7:0] e [6]);
      `CHK("code count", 6, seen.size())
      for (int i = 0; i < 6; i++) `CHK("code", e[i], seen[i])
   endtask
   task automatic t_reset_standby;
      wb(1'b0, A_CTRL, 32'h0, q, n);
      `CHK("ctrl", 10'h001, q[9:0])
      wr(A_Q, 32'h33);
      wb(1'b0, A_IST, 32'h0, q, n);
      `CHK("drop flag", 1'b1, q[hppc_pkg::IRQ_DROP])
      `CHK("boost", 1'b0, boost_en)
      wr(A_IEN, 32'h10);
      repeat (2) @(posedge core_clk);
      `CHK("irq on", 1'b1, irq)
      wr(A_ICLR, 32'h10);
      repeat (2) @(posedge core_clk);
      `CHK("irq off", 1'b0, irq)
      wb(1'b0, 8'h3c, 32'h0, q, n);
      `CHK("unmapped", 32'h0, q)
      wr(A_CTRL, 32'h0);
      wb(1'b0, A_STAT, 32'h0, q, n);
      `CHK("state idle", 3'h1, q[2:0])
      wr(A_IEN, 32'h1);
   endtask
   task automatic t_play_ramp;
      seen.delete();
      wr(A_Q, 32'h05);
      n = 0;
      while (irq !== 1'b1 && n < 500) begin @(posedge core_clk); n++; end
      `CHK("wake span", 1'b1, n >= SU && n <= SU + 4)
      wr(A_IEN, 32'h0);
      n = 0;
      while (rx_code !== 8'h05 && n < 500) begin @(posedge core_clk); n++; end
      `CHK("link code", 8'h05, rx_code)
      wr(A_ICLR, 32'h1f);
      q = 32'h0;
      for (int i = 0; i < 300 && q[2:0] !== 3'h7; i++)
         wb(1'b0, A_STAT, 32'h0, q, n);
      `CHK("ramp state", 3'h7, q[2:0])
      wr(A_Q, 32'h44);
      wb(1'b0, A_IST, 32'h0, q, n);
      `CHK("ramp drop", 1'b1, q[hppc_pkg::IRQ_DROP])
      wait_boost(1'b0);
      `CHK("idle off", 1'b0, boost_en)
      chk_seen('{8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00});
   endtask
   task automatic t_full;
      seen.delete();
      for (int i = 0; i < 4; i++) begin
         wr(A_Q, {24'h0, 8'h7f - 8'(i * 8'h37)});
      end
      wb(1'b1, A_Q, 32'h01, q, n);
      `CHK("stall", 1'b1, n > SU / 2)
      wb(1'b0, A_IST, 32'h0, q, n);
      `CHK("full flag", 1'b1, q[hppc_pkg::IRQ_FULL])
      wait_boost(1'b0);
      chk_seen('{8'h7f, 8'h48, 8'h11, 8'hda, 8'h01, 8'h00});
   endtask
   task automatic t_play_cmd;
      // Play bit in memory playback mode, second timeout step selected
      wr(A_CTRL, 32'h2a0);
      wait_boost(1'b1);
      `CHK("play wake", 1'b1, boost_en)
      wait_boost(1'b0);
      `CHK("tmo span", 1'b1, n - SU - 2 * TS inside {[1:SC]})
      wb(1'b0, A_CTRL, 32'h0, q, n);
      `CHK("play cleared", 10'h0a0, q[9:0])
   endtask
   task automatic t_force_gain_srst;
      wr(A_CTRL, 32'h2);
      wait_boost(1'b1);
      `CHK("force fast", 1'b1, n <= 5)
      repeat (SU + 3 * TS) @(posedge core_clk);
      `CHK("force hold", 1'b1, boost_en)
      wr(A_CTRL, 32'h1);
      repeat (4) @(posedge core_clk);
      `CHK("standby off", 1'b0, boost_en)
      for (int g = 0; g < 4; g++) begin
         wr(A_CTRL, 32'(g) << hppc_pkg::CTRL_GAIN);
         repeat (3) @(posedge core_clk);
         `CHK("gain", 2'(g), gain_sel)
      end
      wr(A_CTRL, 32'h1a);
      wait_boost(1'b1);
      wr(A_CTRL, 32'h4);
      wb(1'b0, A_CTRL, 32'h0, q, n);
      `CHK("srst ctrl", 10'h001, q[9:0])
      `CHK("srst stages", 1'b0, boost_en)
      `CHK("srst gain", 2'h0, gain_sel)
   endtask
   task end_sim;
      if (miscompares == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      last_code = 8'h00;
      miscompares = 0;
      checked = 0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      t_reset_standby();
      t_play_ramp();
      t_full();
      t_play_cmd();
      t_force_gain_srst();
      end_sim();
   end
   initial begin
      #500us;
      miscompares++;
      end_sim();
   end
endmodule
bind hppc_top hppc_monitor u_mon (.core_clk(core_clk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dac(dac),
   .conv_code(conv_code), .boost_en(boost_en), .amp_en(amp_en),
   .gain_sel(gain_sel), .irq(irq));
